// ===== sfs_defines.svh
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH
// Register addresses
`define SFS_ADDR_SUPPLY 8'h02
`define SFS_ADDR_MEMTEMP 8'h03
`define SFS_ADDR_LINK 8'h04
// Supply status bit positions
`define SFS_SUP_UV_BIT 7
`define SFS_SUP_ANA_BIT 3
`define SFS_SUP_DIG_BIT 2
`define SFS_SUP_OTP_BIT 1
`define SFS_SUP_SEAL_BIT 0
// Memory/temperature status bit positions
`define SFS_MT_FOTP_BIT 7
`define SFS_MT_UOTP_BIT 6
`define SFS_MT_URW_BIT 5
`define SFS_MT_UWA_BIT 4
`define SFS_MT_TEMP_BIT 2
// Link status bit position
`define SFS_LINK_MISO_BIT 7
// Reset values
`define SFS_REG_RESET 8'h00
// Supply recovery time in microseconds, clock period in ns
`define SFS_RCV_TIME_US 100
`define SFS_CLK_PERIOD_NS 10
`define SFS_RCV_CYCLES ((`SFS_RCV_TIME_US * 1000) / `SFS_CLK_PERIOD_NS)
`endif

// ===== sfs_host_model.sv
// ********
// Host reading status
// ********
module sfs_host_model
  import sfs_pkg::*;
(
  // Register access
  input wire logic sys_clk,
  input wire sfs_byte_type reg_rdata,
  output logic reg_rd,
  output logic [7:0] reg_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_rd, reg_addr} = 9'h000;
  // Only called once reset is over, so supply flags are never judged mid-reset
  task automatic rd(input logic [7:0] a, output sfs_byte_type d);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    // Read data stands for one cycle only, so take it before releasing
    d = reg_rdata;
    reg_rd = 1'b0;
    // Released address shows its inverse so stale values are not trusted
    reg_addr = ~a;
  endtask
endmodule

// ===== sfs_pkg.sv
package sfs_pkg;
  typedef logic [7:0] sfs_byte_type;
endpackage

// ===== sfs_status_flags.sv
`include "sfs_defines.svh"

// Behaviour
// - Supply bit 3 set while analog regulator is out of limits.
// - Supply bit 2 set while digital regulator is out of limits.
// - Supply bit 1 set while OTP regulator is out of limits.
// - Supply bit 0 set when edge seal continuity break is detected.
// - One shared recovery timer reloads whenever any supply error is present.
// - Memory bit 7 set on factory OTP array fault.
// - Memory bit 6 set on user OTP array fault.
// - After init lock, check code mismatch on user registers sets bit 5.
// - Memory bit 4 follows a user OTP write in progress.
// - Memory bit 2 set on over or under temperature.
// - Memory error bits clear on register read or status transmission.
// - Link bit 7 set on MISO data mismatch in SPI mode.
// - MISO flag clears on link register read or SPI status report.
// - Summary: memory OR of bits, link copies MISO flag.
// - Supply summary is OR of the five supply flags.
// - In SPI with reporting enabled, supply clear waits for timer zero.
module sfs_status_flags
  import sfs_pkg::*;
#(
  parameter int RCV_CYCLES = `SFS_RCV_CYCLES
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register access port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  output sfs_byte_type reg_rdata,
  // Status transmission reports
  input wire logic report_supply,
  input wire logic report_memtemp,
  input wire logic report_link,
  // Mode and control
  input wire logic spi_mode,
  input wire logic supply_report_disable,
  input wire logic init_complete_lock,
  input wire logic [7:0] check_code_calc,
  input wire logic [7:0] check_code_stored,
  // Fault detector pins
  input wire logic supply_undervoltage_fault_pin,
  input wire logic analog_regulator_fault_pin,
  input wire logic digital_regulator_fault_pin,
  input wire logic otp_regulator_fault_pin,
  input wire logic edge_seal_break_pin,
  input wire logic factory_otp_fault_pin,
  input wire logic user_otp_fault_pin,
  input wire logic user_otp_write_busy_pin,
  input wire logic temperature_limit_pin,
  input wire logic miso_mismatch_pin,
  // Status outputs
  output sfs_byte_type supply_fault_status,
  output sfs_byte_type memory_temp_fault_status,
  output sfs_byte_type link_fault_status,
  output logic supply_summary,
  output logic memory_temp_summary,
  output logic link_summary,
  output logic supply_timer_zero
);

  localparam int NPIN = 10;
  localparam int TW = $clog2(RCV_CYCLES + 1);

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Detectors run off other supplies, so every fault pin is treated as asynchronous
  logic [NPIN-1:0] sync_a;
  logic [NPIN-1:0] sync_b;
  logic [NPIN-1:0] next_sync_a;
  logic [NPIN-1:0] next_sync_b;

  always_comb
  begin
    next_sync_a = {supply_undervoltage_fault_pin, analog_regulator_fault_pin,
                   digital_regulator_fault_pin, otp_regulator_fault_pin,
                   edge_seal_break_pin, factory_otp_fault_pin, user_otp_fault_pin,
                   user_otp_write_busy_pin, temperature_limit_pin, miso_mismatch_pin};
    next_sync_b = sync_a;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
    end
  end

  logic uv_in, ana_in, dig_in, otpr_in, seal_in, fotp_in, uotp_in, uwa_in, temp_in, miso_in;
  assign {uv_in, ana_in, dig_in, otpr_in, seal_in, fotp_in, uotp_in, uwa_in, temp_in,
          miso_in} = sync_b;

  // ****************************************
  // Flags, recovery timer and read port
  // ****************************************
  logic [4:0] sup_flags;
  logic [4:0] next_sup_flags;
  logic [3:0] mt_flags;
  logic [3:0] next_mt_flags;
  logic uwa_flag;
  logic next_uwa_flag;
  logic miso_flag;
  logic next_miso_flag;
  logic [TW-1:0] rcv_timer;
  logic [TW-1:0] next_rcv_timer;
  sfs_byte_type next_rdata;
  sfs_byte_type sup_byte;
  sfs_byte_type mt_byte;
  sfs_byte_type link_byte;

  function automatic logic rd_hit(input logic rd, input logic [7:0] addr,
                                  input logic [7:0] target);
    rd_hit = rd && (addr == target);
  endfunction

  logic rd_sup, rd_mt, rd_link, any_sup_err, sup_clear, mt_clear, link_clear, crc_err;

  always_comb
  begin
    rd_sup = rd_hit(reg_rd, reg_addr, `SFS_ADDR_SUPPLY);
    rd_mt = rd_hit(reg_rd, reg_addr, `SFS_ADDR_MEMTEMP);
    rd_link = rd_hit(reg_rd, reg_addr, `SFS_ADDR_LINK);
    any_sup_err = uv_in | ana_in | dig_in | otpr_in | seal_in;
    // Reload while any error is present, else count down to zero
    // The timer is shared, so one late fault holds back every supply bit
    if (any_sup_err)
      next_rcv_timer = TW'(RCV_CYCLES);
    else if (rcv_timer != '0)
      next_rcv_timer = rcv_timer - TW'(1);
    else
      next_rcv_timer = rcv_timer;
    // Clearing never happens before the timer has run out
    if (spi_mode && supply_report_disable)
      sup_clear = (rcv_timer == '0);
    else
      sup_clear = (rd_sup || (report_supply && spi_mode)) && (rcv_timer == '0);
    // Set wins over clear: a live fault keeps its bit high
    next_sup_flags = (sup_clear ? 5'h00 : sup_flags) |
                     {uv_in, ana_in, dig_in, otpr_in, seal_in};
    // Check runs only once locked: before that, user writes are expected
    crc_err = init_complete_lock && (check_code_calc != check_code_stored);
    mt_clear = rd_mt || report_memtemp;
    next_mt_flags = (mt_clear ? 4'h0 : mt_flags) |
                    {fotp_in, uotp_in, crc_err, temp_in};
    // Busy bit is a live level with no clear of its own; it drops when the write ends
    next_uwa_flag = uwa_in;
    link_clear = rd_link || (report_link && spi_mode);
    next_miso_flag = (link_clear ? 1'b0 : miso_flag) | (miso_in & spi_mode);
    sup_byte = `SFS_REG_RESET;
    sup_byte[`SFS_SUP_UV_BIT] = sup_flags[4];
    sup_byte[`SFS_SUP_ANA_BIT] = sup_flags[3];
    sup_byte[`SFS_SUP_DIG_BIT] = sup_flags[2];
    sup_byte[`SFS_SUP_OTP_BIT] = sup_flags[1];
    sup_byte[`SFS_SUP_SEAL_BIT] = sup_flags[0];
    mt_byte = `SFS_REG_RESET;
    mt_byte[`SFS_MT_FOTP_BIT] = mt_flags[3];
    mt_byte[`SFS_MT_UOTP_BIT] = mt_flags[2];
    mt_byte[`SFS_MT_URW_BIT] = mt_flags[1];
    mt_byte[`SFS_MT_UWA_BIT] = uwa_flag;
    mt_byte[`SFS_MT_TEMP_BIT] = mt_flags[0];
    link_byte = `SFS_REG_RESET;
    link_byte[`SFS_LINK_MISO_BIT] = miso_flag;
    // Writes have no path here; reserved bits stay zero
    // reg_wr is left unread on purpose: a write can never touch a flag
    next_rdata = `SFS_REG_RESET;
    if (rd_sup)
      next_rdata = sup_byte;
    else if (rd_mt)
      next_rdata = mt_byte;
    else if (rd_link)
      next_rdata = link_byte;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sup_flags <= '0;
      mt_flags <= '0;
      uwa_flag <= 1'b0;
      miso_flag <= 1'b0;
      rcv_timer <= '0;
      reg_rdata <= `SFS_REG_RESET;
      supply_fault_status <= `SFS_REG_RESET;
      memory_temp_fault_status <= `SFS_REG_RESET;
      link_fault_status <= `SFS_REG_RESET;
      supply_summary <= 1'b0;
      memory_temp_summary <= 1'b0;
      link_summary <= 1'b0;
      supply_timer_zero <= 1'b1;
    end
    else
    begin
      sup_flags <= next_sup_flags;
      mt_flags <= next_mt_flags;
      uwa_flag <= next_uwa_flag;
      miso_flag <= next_miso_flag;
      rcv_timer <= next_rcv_timer;
      reg_rdata <= next_rdata;
      supply_fault_status <= sup_byte;
      memory_temp_fault_status <= mt_byte;
      link_fault_status <= link_byte;
      supply_summary <= |sup_flags;
      memory_temp_summary <= (|mt_flags) | uwa_flag;
      link_summary <= miso_flag;
      supply_timer_zero <= (rcv_timer == '0);
    end
  end

endmodule

// ===== sfs_status_flags_assertions.sv
// ********
// Port checks
// ********
module sfs_status_flags_checker
  import sfs_pkg::*;
(
  // Clock, reset, access and fault pins
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic analog_regulator_fault_pin,
  input wire logic factory_otp_fault_pin,
  // Status
  input wire sfs_byte_type reg_rdata,
  input wire sfs_byte_type supply_fault_status,
  input wire sfs_byte_type memory_temp_fault_status,
  input wire sfs_byte_type link_fault_status,
  input wire logic supply_summary,
  input wire logic memory_temp_summary,
  input wire logic link_summary
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_mt_read;
    reg_rd && reg_addr == 8'h03;
  endsequence
  a_ana_sets: assert property (
    $rose(analog_regulator_fault_pin) |-> ##[1:6] supply_fault_status[3]) else $error("ana");
  a_fotp_sets: assert property (
    $rose(factory_otp_fault_pin) |-> ##[1:6] memory_temp_fault_status[7]) else $error("fotp");
  a_reserved_zero: assert property (
    ((supply_fault_status & 8'h70) | (memory_temp_fault_status & 8'h0B)
    | (link_fault_status & 8'h7F)) == 8'h00) else $error("reserved");
  a_link_summary: assert property (
    link_summary == link_fault_status[7]) else $error("link sum");
  a_mt_summary: assert property (
    memory_temp_summary == (|memory_temp_fault_status)) else $error("mt sum");
  a_sup_summary: assert property (
    supply_summary == (|supply_fault_status)) else $error("sup sum");
  a_mt_rdata: assert property (
    s_mt_read |=> reg_rdata == memory_temp_fault_status) else $error("mt rdata");
  a_mt_clears: assert property (
    s_mt_read ##0 !$past(factory_otp_fault_pin, 1) && !$past(factory_otp_fault_pin, 2)
    |-> ##3 !memory_temp_fault_status[7]) else $error("mt clear");
endmodule
bind sfs_status_flags sfs_status_flags_checker chk_i (.*);

// ===== sfs_status_flags_tb.sv
// ********
// Bench
// ********
`define CHK(n, e, g) chk(n, e, g)
module sfs_status_flags_tb;
  import sfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd, st, mt, lt, tz;
  logic [9:0] pins = 10'h000;
  logic [5:0] ctl = 6'h00;
  logic [7:0] reg_addr, calc = 8'h00;
  sfs_byte_type reg_rdata, sup, mem, lnk, d;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  sfs_host_model host_i (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rd(reg_rd),
    .reg_addr(reg_addr));
  sfs_status_flags #(.RCV_CYCLES(8)) sfs_status_flags_i (.sys_clk(sys_clk), .rstn(rstn),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .report_supply(ctl[0]), .report_memtemp(ctl[1]), .report_link(ctl[2]),
    .spi_mode(ctl[3]), .supply_report_disable(ctl[4]), .init_complete_lock(ctl[5]),
    .check_code_calc(calc), .check_code_stored(8'h5A),
    .supply_undervoltage_fault_pin(pins[0]), .analog_regulator_fault_pin(pins[1]),
    .digital_regulator_fault_pin(pins[2]), .otp_regulator_fault_pin(pins[3]),
    .edge_seal_break_pin(pins[4]), .factory_otp_fault_pin(pins[5]),
    .user_otp_fault_pin(pins[6]), .user_otp_write_busy_pin(pins[7]),
    .temperature_limit_pin(pins[8]), .miso_mismatch_pin(pins[9]),
    .supply_fault_status(sup), .memory_temp_fault_status(mem), .link_fault_status(lnk),
    .supply_summary(st), .memory_temp_summary(mt), .link_summary(lt),
    .supply_timer_zero(tz));
  task automatic chk(string n, sfs_byte_type e, sfs_byte_type g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_supply();
    pins = 10'h01F;
    wt(6);
    `CHK("sup", 8'h8F, sup);
    `CHK("sup sum", 8'h01, 8'(st));
    pins = 10'h000;
    host_i.rd(8'h02, d);
    `CHK("sup rd", 8'h8F, d);
    wt(1);
    `CHK("sup held", 8'h8F, sup);
    `CHK("tz busy", 8'h00, 8'(tz));
    wt(15);
    `CHK("tz done", 8'h01, 8'(tz));
    host_i.rd(8'h02, d);
    `CHK("sup rd2", 8'h8F, d);
    wt(1);
    `CHK("sup clr", 8'h00, sup);
    $display("t_supply done");
  endtask
  task automatic t_memtemp();
    ctl[5] = 1'b1;
    pins = 10'h1E0;
    wt(6);
    `CHK("mt", 8'hF4, mem);
    `CHK("mt fotp", 8'h80, mem & 8'h80);
    `CHK("mt uotp", 8'h40, mem & 8'h40);
    `CHK("mt sum", 8'h01, 8'(mt));
    pins = 10'h080;
    calc = 8'h5A;
    wt(4);
    host_i.rd(8'h03, d);
    `CHK("mt rd", 8'hF4, d);
    wt(1);
    `CHK("mt busy", 8'h10, mem);
    pins = 10'h100;
    wt(6);
    pins = 10'h000;
    wt(3);
    `CHK("mt temp", 8'h04, mem);
    ctl[1] = 1'b1;
    wt(1);
    ctl[1] = 1'b0;
    wt(3);
    `CHK("mt rep", 8'h00, mem);
    `CHK("mt sum clr", 8'h00, 8'(mt));
    $display("t_memtemp done");
  endtask
  task automatic t_link();
    reg_wr = 1'b1;
    ctl[3] = 1'b1;
    pins = 10'h200;
    wt(2);
    pins = 10'h000;
    wt(6);
    `CHK("lnk", 8'h80, lnk);
    `CHK("lnk sum", 8'h01, 8'(lt));
    ctl[2] = 1'b1;
    wt(1);
    ctl[2] = 1'b0;
    wt(4);
    `CHK("lnk rep", 8'h00, lnk);
    pins = 10'h200;
    wt(2);
    pins = 10'h000;
    wt(6);
    host_i.rd(8'h04, d);
    `CHK("lnk rd", 8'h80, d);
    wt(1);
    `CHK("lnk rd clr", 8'h00, lnk);
    ctl[3] = 1'b0;
    pins = 10'h200;
    wt(2);
    pins = 10'h000;
    wt(6);
    `CHK("lnk i2c", 8'h00, lnk);
    reg_wr = 1'b0;
    host_i.rd(8'h05, d);
    `CHK("unmapped", 8'h00, d);
    $display("t_link done");
  endtask
  task automatic t_supply_mode();
    ctl[3] = 1'b1;
    pins = 10'h004;
    wt(2);
    pins = 10'h000;
    wt(2);
    `CHK("sup dig", 8'h04, sup);
    ctl[0] = 1'b1;
    wt(1);
    ctl[0] = 1'b0;
    wt(1);
    `CHK("rep early", 8'h04, sup);
    wt(7);
    `CHK("rep tz", 8'h01, 8'(tz));
    `CHK("rep wait", 8'h04, sup);
    ctl[0] = 1'b1;
    wt(1);
    ctl[0] = 1'b0;
    wt(1);
    `CHK("rep clr", 8'h00, sup);
    ctl[4] = 1'b1;
    pins = 10'h008;
    wt(2);
    pins = 10'h000;
    wt(4);
    `CHK("auto held", 8'h02, sup);
    `CHK("auto sum", 8'h01, 8'(st));
    wt(9);
    `CHK("auto clr", 8'h00, sup);
    ctl[4] = 1'b0;
    ctl[3] = 1'b0;
    $display("t_supply_mode done");
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      summarize();
    end
  end
  initial
  begin
    wt(2);
    rstn = 1'b1;
    t_supply();
    t_memtemp();
    t_link();
    t_supply_mode();
    summarize();
  end
endmodule
